// ### hw/fsl_pkg.sv
package fsl_pkg;
   // ***************
   // timing
   // ***************
   localparam int CLK_KHZ = 10000;
   localparam int FLASH_MS = 200;
   localparam int GAP_MS = 1000;
   // ms times kHz gives cycles; 2,000,000 fits an int
   localparam int PHASE_CYC = FLASH_MS * CLK_KHZ;
   localparam int GAP_PHASES = GAP_MS / FLASH_MS;
   localparam int CNT_W = 32;

   // ***************
   // backplane limits
   // ***************
   localparam logic [5:0] MAX_MODULES = 6'h20;
   localparam logic [7:0] MAX_IMG_BYTES = 8'h40;

   // ***************
   // register map
   // ***************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_EN = 8'h0C;
   localparam logic [7:0] ADDR_INT_CLR = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TEST_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [5:0] INT_EN_RST = 6'h00;

   // ***************
   // events and indicator channels
   // ***************
   localparam int NUM_EV = 6;
   localparam int EV_BUSOFF = 0;
   localparam int EV_GUARD = 1;
   localparam int EV_SYNC = 2;
   localparam int EV_IO_FAULT = 3;
   localparam int EV_INIT_FAIL = 4;
   localparam int EV_FP_LOST = 5;
   localparam int NUM_LED = 5;
   localparam int LED_RUN = 0;
   localparam int LED_ERR = 1;
   localparam int LED_IO_G = 2;
   localparam int LED_IO_R = 3;
   localparam int LED_FP = 4;

   typedef enum logic [1:0] {NMT_BOOT, NMT_STOPPED, NMT_PREOP, NMT_OPER} fsl_nmt_e;
   typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_BLINK, PAT_FLASH1, PAT_FLASH2,
                             PAT_FLASH3} fsl_pat_e;

   typedef struct packed {
      logic online;
      logic unit_pwr;
      fsl_nmt_e nmt;
      logic can_warn;
      logic bus_off;
      logic guard_trip;
      logic sync_err;
   } fsl_net_s;

   typedef struct packed {
      logic present;
      logic powered;
      logic online;
      logic init_done;
      logic exch;
      logic mod_fault;
      logic cfg_changed;
      logic comm_fail;
      logic bad_id;
      logic proto_fail;
      logic [5:0] mod_count;
      logic [7:0] in_bytes;
      logic [7:0] out_bytes;
   } fsl_bp_s;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } fsl_tick_s;

   typedef struct packed {
      fsl_pat_e pat;
      logic [3:0] slot;
      logic lit;
   } fsl_flash_s;

   typedef struct packed {
      logic [1:0] ctrl;
      logic [NUM_EV-1:0] int_stat;
      logic [NUM_EV-1:0] int_en;
      logic guard_flag;
      logic sync_flag;
      logic prev_busoff;
      logic prev_io_fault;
      logic prev_init_fail;
      logic prev_fp;
      logic prev_oper;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic [NUM_LED-1:0] leds;
      logic pdo_en;
      logic preop_req;
      logic irq;
   } fsl_top_s;
endpackage

// ### hw/fsl_tick.sv
`timescale 1ns/1ps
`default_nettype none
module fsl_tick #(
   parameter int unsigned CYC = fsl_pkg::PHASE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic tick
);
   fsl_pkg::fsl_tick_s r_reg;
   fsl_pkg::fsl_tick_s r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (r_reg.cnt == fsl_pkg::CNT_W'(CYC - 1)) begin
         r_next.cnt = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tick = r_reg.tick;
endmodule
`default_nettype wire

// ### hw/fsl_flash.sv
`timescale 1ns/1ps
`default_nettype none
module fsl_flash (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire fsl_pkg::fsl_pat_e pat,
   output logic lit
);
   fsl_pkg::fsl_flash_s r_reg;
   fsl_pkg::fsl_flash_s r_next;
   logic [3:0] len;
   logic [3:0] pulses;

   always_comb begin
      r_next = r_reg;
      pulses = 4'h0;
      len = 4'h1;
      case (pat)
         fsl_pkg::PAT_BLINK: len = 4'h2;
         fsl_pkg::PAT_FLASH1: pulses = 4'h1;
         fsl_pkg::PAT_FLASH2: pulses = 4'h2;
         fsl_pkg::PAT_FLASH3: pulses = 4'h3;
         default: len = 4'h1;
      endcase
      // n pulses with n-1 gaps, then the long dark gap
      if (pulses != 4'h0) begin
         len = 4'((pulses << 1) - 4'h1 + 4'(fsl_pkg::GAP_PHASES));
      end
      r_next.pat = pat;
      // a new pattern restarts at its first lit phase
      if (pat != r_reg.pat) begin
         r_next.slot = 4'h0;
      end else if (tick) begin
         r_next.slot = (r_reg.slot >= len - 4'h1) ? 4'h0 : r_reg.slot + 4'h1;
      end
      case (pat)
         fsl_pkg::PAT_ON: r_next.lit = 1'b1;
         fsl_pkg::PAT_BLINK: r_next.lit = ~r_next.slot[0];
         fsl_pkg::PAT_FLASH1, fsl_pkg::PAT_FLASH2, fsl_pkg::PAT_FLASH3: begin
            r_next.lit = (r_next.slot < (pulses << 1)) && !r_next.slot[0];
         end
         default: r_next.lit = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign lit = r_reg.lit;
endmodule
`default_nettype wire

// ### hw/fsl_top.sv
// Behaviour
// - run indicator dark when node off-line or unit power missing.
// - run indicator solid green in Operational.
// - run indicator single green flash in Stopped.
// - run indicator blinks green in Pre-Operational.
// - single red flash at CAN warning level; dark with no error.
// - guarding loss gives double red flash and falls back to Pre-Operational.
// - sync error gives triple red flash, Pre-Operational, process data disabled.
// - error indicator solid red during bus-off.
// - backplane indicator dark with no modules or no backplane power.
// - backplane indicator blinks green while modules initialise, no exchange.
// - backplane indicator solid green while exchanging after full initialisation.
// - solid red on module fault, configuration change or communication loss.
// - blinking red on failed initialisation: bad id, too many modules, oversize, protocol.
// - field power indicator solid green while 24 V field supply present.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsl_top #(
   parameter int unsigned PHASE_CYC = fsl_pkg::PHASE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire fsl_pkg::fsl_net_s net,
   input wire fsl_pkg::fsl_bp_s bp,
   input wire logic field_pwr_ok,
   output logic led_run_g,
   output logic led_err_r,
   output logic led_io_g,
   output logic led_io_r,
   output logic led_fp_g,
   output logic pdo_en,
   output logic preop_req,
   output logic irq
);
   fsl_pkg::fsl_top_s r_reg;
   fsl_pkg::fsl_top_s r_next;
   fsl_pkg::fsl_pat_e pats [fsl_pkg::NUM_LED];
   logic [fsl_pkg::NUM_LED-1:0] lit;
   logic tick;

   // ***************
   // shared phase timebase
   // ***************
   fsl_tick #(
      .CYC(PHASE_CYC)
   ) u_tick (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick)
   );

   // ***************
   // one pattern engine per indicator colour
   // ***************
   genvar gi;
   generate
      for (gi = 0; gi < fsl_pkg::NUM_LED; gi++) begin : g_led
         fsl_flash u_flash (
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick),
            .pat(pats[gi]),
            .lit(lit[gi])
         );
      end
   endgenerate

   // ***************
   // indicator decisions
   // ***************
   logic oper_now;
   logic fallback;
   fsl_pkg::fsl_nmt_e eff_nmt;
   logic init_fail;
   logic io_fault;
   logic bp_off;

   always_comb begin
      oper_now = (net.nmt == fsl_pkg::NMT_OPER);
      // latched guarding or sync trouble overrides an Operational stack state
      fallback = r_reg.guard_flag || r_reg.sync_flag;
      eff_nmt = (fallback && oper_now) ? fsl_pkg::NMT_PREOP : net.nmt;
      bp_off = !bp.present || !bp.powered;
      init_fail = bp.bad_id || bp.proto_fail
                  || (bp.mod_count > fsl_pkg::MAX_MODULES)
                  || (bp.in_bytes > fsl_pkg::MAX_IMG_BYTES)
                  || (bp.out_bytes > fsl_pkg::MAX_IMG_BYTES);
      io_fault = bp.exch && (bp.mod_fault || bp.cfg_changed || bp.comm_fail);

      // run indicator
      if (!net.online || !net.unit_pwr) begin
         pats[fsl_pkg::LED_RUN] = fsl_pkg::PAT_OFF;
      end else begin
         case (eff_nmt)
            fsl_pkg::NMT_OPER: pats[fsl_pkg::LED_RUN] = fsl_pkg::PAT_ON;
            fsl_pkg::NMT_STOPPED: pats[fsl_pkg::LED_RUN] = fsl_pkg::PAT_FLASH1;
            fsl_pkg::NMT_PREOP: pats[fsl_pkg::LED_RUN] = fsl_pkg::PAT_BLINK;
            default: pats[fsl_pkg::LED_RUN] = fsl_pkg::PAT_OFF;
         endcase
      end

      // error indicator, most severe first
      if (net.bus_off) begin
         pats[fsl_pkg::LED_ERR] = fsl_pkg::PAT_ON;
      end else if (r_reg.sync_flag) begin
         pats[fsl_pkg::LED_ERR] = fsl_pkg::PAT_FLASH3;
      end else if (r_reg.guard_flag) begin
         pats[fsl_pkg::LED_ERR] = fsl_pkg::PAT_FLASH2;
      end else if (net.can_warn) begin
         pats[fsl_pkg::LED_ERR] = fsl_pkg::PAT_FLASH1;
      end else begin
         pats[fsl_pkg::LED_ERR] = fsl_pkg::PAT_OFF;
      end

      // backplane bicolour indicator
      pats[fsl_pkg::LED_IO_G] = fsl_pkg::PAT_OFF;
      pats[fsl_pkg::LED_IO_R] = fsl_pkg::PAT_OFF;
      if (bp_off) begin
         pats[fsl_pkg::LED_IO_G] = fsl_pkg::PAT_OFF;
      end else if (bp.exch) begin
         if (io_fault) begin
            pats[fsl_pkg::LED_IO_R] = fsl_pkg::PAT_ON;
         end else if (bp.init_done) begin
            pats[fsl_pkg::LED_IO_G] = fsl_pkg::PAT_ON;
         end else begin
            pats[fsl_pkg::LED_IO_G] = fsl_pkg::PAT_BLINK;
         end
      end else if (init_fail) begin
         pats[fsl_pkg::LED_IO_R] = fsl_pkg::PAT_BLINK;
      end else if (bp.online) begin
         pats[fsl_pkg::LED_IO_G] = fsl_pkg::PAT_BLINK;
      end

      pats[fsl_pkg::LED_FP] = field_pwr_ok ? fsl_pkg::PAT_ON : fsl_pkg::PAT_OFF;
   end

   // ***************
   // state update and register slave
   // ***************
   localparam int NUM_EVW = fsl_pkg::NUM_EV;
   logic addr_ok;
   logic [NUM_EVW-1:0] events;
   logic [31:0] rd;

   always_comb begin
      r_next = r_reg;
      addr_ok = hsel && htrans[1] && hready;
      rd = 32'h0000_0000;

      // events except guard and sync are taken from input edges so a held level raises one flag; guard and sync follow their levels
      events = '0;
      events[fsl_pkg::EV_BUSOFF] = net.bus_off && !r_reg.prev_busoff;
      events[fsl_pkg::EV_GUARD] = net.guard_trip;
      events[fsl_pkg::EV_SYNC] = net.sync_err;
      events[fsl_pkg::EV_IO_FAULT] = io_fault && !r_reg.prev_io_fault;
      events[fsl_pkg::EV_INIT_FAIL] = init_fail && !r_reg.prev_init_fail;
      events[fsl_pkg::EV_FP_LOST] = !field_pwr_ok && r_reg.prev_fp;
      r_next.prev_busoff = net.bus_off;
      r_next.prev_io_fault = io_fault;
      r_next.prev_init_fail = init_fail;
      r_next.prev_fp = field_pwr_ok;
      r_next.prev_oper = oper_now;

      // fallback flags clear when the master restarts the node; trip wins
      if (oper_now && !r_reg.prev_oper) begin
         r_next.guard_flag = 1'b0;
         r_next.sync_flag = 1'b0;
      end
      if (net.guard_trip) begin
         r_next.guard_flag = 1'b1;
      end
      if (net.sync_err) begin
         r_next.sync_flag = 1'b1;
      end
      r_next.preop_req = (r_next.guard_flag || r_next.sync_flag) && oper_now;
      r_next.pdo_en = oper_now && !r_next.sync_flag && !r_next.guard_flag;

      // data phase of a write
      if (r_reg.dp_wr) begin
         case (r_reg.dp_addr)
            fsl_pkg::ADDR_CTRL: r_next.ctrl = hwdata[1:0];
            fsl_pkg::ADDR_INT_EN: r_next.int_en = hwdata[NUM_EVW-1:0];
            fsl_pkg::ADDR_INT_CLR: r_next.int_stat = r_reg.int_stat & ~hwdata[NUM_EVW-1:0];
            default: r_next.ctrl = r_reg.ctrl;
         endcase
      end
      // set after clear so a same-cycle event survives
      r_next.int_stat = r_next.int_stat | events;

      // address phase; read data captured now, presented in the data phase
      r_next.dp_wr = addr_ok && hwrite;
      r_next.dp_addr = haddr[7:0];
      if (addr_ok && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
         case (haddr[7:0])
            fsl_pkg::ADDR_CTRL: rd[1:0] = r_next.ctrl;
            fsl_pkg::ADDR_STATUS: begin
               rd[fsl_pkg::NUM_LED-1:0] = r_reg.leds;
               rd[8] = r_next.guard_flag;
               rd[9] = r_next.sync_flag;
               rd[10] = r_next.pdo_en;
               rd[11] = init_fail;
               rd[12] = io_fault;
               rd[14:13] = net.nmt;
            end
            fsl_pkg::ADDR_INT_STAT: rd[NUM_EVW-1:0] = r_next.int_stat;
            fsl_pkg::ADDR_INT_EN: rd[NUM_EVW-1:0] = r_next.int_en;
            default: rd = 32'h0000_0000;
         endcase
      end
      // other high addresses decode to nothing: reads zero, writes dropped
      if (haddr[31:8] != 24'h00_0000) begin
         r_next.dp_wr = 1'b0;
      end
      r_next.hrdata = rd;
      r_next.hreadyout = 1'b1;
      r_next.hresp = 1'b0;

      // lamp test lights every colour and wins over disable; with the test off, disable darkens all
      if (r_next.ctrl[fsl_pkg::CTRL_TEST_BIT]) begin
         r_next.leds = '1;
      end else if (r_next.ctrl[fsl_pkg::CTRL_EN_BIT]) begin
         r_next.leds = lit;
      end else begin
         r_next.leds = '0;
      end
      r_next.irq = |(r_next.int_stat & r_next.int_en);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.ctrl <= fsl_pkg::CTRL_RST;
         r_reg.int_en <= fsl_pkg::INT_EN_RST;
         r_reg.hreadyout <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ***************
   // outputs, all from flops
   // ***************
   assign hrdata = r_reg.hrdata;
   assign hreadyout = r_reg.hreadyout;
   assign hresp = r_reg.hresp;
   assign led_run_g = r_reg.leds[fsl_pkg::LED_RUN];
   assign led_err_r = r_reg.leds[fsl_pkg::LED_ERR];
   assign led_io_g = r_reg.leds[fsl_pkg::LED_IO_G];
   assign led_io_r = r_reg.leds[fsl_pkg::LED_IO_R];
   assign led_fp_g = r_reg.leds[fsl_pkg::LED_FP];
   assign pdo_en = r_reg.pdo_en;
   assign preop_req = r_reg.preop_req;
   assign irq = r_reg.irq;
endmodule
`default_nettype wire

// ### bench/fsl_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// port-level checks for the indicator block
// *****
module fsl_props #(
   parameter int unsigned PHASE_CYC = fsl_pkg::PHASE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire fsl_pkg::fsl_net_s net,
   input wire fsl_pkg::fsl_bp_s bp,
   input wire logic field_pwr_ok,
   input wire logic led_run_g,
   input wire logic led_err_r,
   input wire logic led_io_g,
   input wire logic led_io_r,
   input wire logic led_fp_g,
   input wire logic pdo_en,
   input wire logic preop_req
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_io_live;
      bp.present && bp.powered;
   endsequence
   sequence s_guard_hit;
      net.guard_trip && net.nmt == fsl_pkg::NMT_OPER;
   endsequence
   property p_run_dark; !(net.online && net.unit_pwr) |-> ##2 !led_run_g; endproperty
   a_run_dark: assert property (p_run_dark) else $error("run lamp lit off-line");
   property p_busoff; net.bus_off |-> ##2 led_err_r; endproperty
   a_busoff: assert property (p_busoff) else $error("bus-off lamp dark");
   property p_guard; s_guard_hit |=> preop_req && !pdo_en; endproperty
   a_guard: assert property (p_guard) else $error("guard loss not handled");
   property p_sync; net.sync_err |=> !pdo_en; endproperty
   a_sync: assert property (p_sync) else $error("process data left on");
   property p_io_dark; !(bp.present && bp.powered) |-> ##2 !led_io_g && !led_io_r; endproperty
   a_io_dark: assert property (p_io_dark) else $error("backplane lamp lit");
   property p_io_green;
      s_io_live ##0 (bp.exch && bp.init_done && !bp.mod_fault && !bp.cfg_changed
         && !bp.comm_fail) |-> ##2 led_io_g && !led_io_r;
   endproperty
   a_io_green: assert property (p_io_green) else $error("exchange not green");
   property p_io_red;
      s_io_live ##0 (bp.exch && (bp.mod_fault || bp.cfg_changed || bp.comm_fail))
         |-> ##2 led_io_r && !led_io_g;
   endproperty
   a_io_red: assert property (p_io_red) else $error("fault not red");
   property p_io_fail;
      s_io_live ##0 (!bp.exch && (bp.bad_id || bp.proto_fail || bp.mod_count > 6'h20))
         |-> ##2 !led_io_g;
   endproperty
   a_io_fail: assert property (p_io_fail) else $error("failed init shown green");
   property p_fp; field_pwr_ok ##1 !field_pwr_ok |-> ##1 led_fp_g ##1 !led_fp_g; endproperty
   a_fp: assert property (p_fp) else $error("field power lamp wrong");
   property p_rd_idle; !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
   property p_okay; hsel |-> hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("slave not ready or error");
endmodule
bind fsl_top fsl_props #(.PHASE_CYC(PHASE_CYC)) chk_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .net(net), .bp(bp), .field_pwr_ok(field_pwr_ok),
   .led_run_g(led_run_g), .led_err_r(led_err_r), .led_io_g(led_io_g), .led_io_r(led_io_r),
   .led_fp_g(led_fp_g), .pdo_en(pdo_en), .preop_req(preop_req));
`default_nettype wire

// ### bench/fsl_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// network stack and backplane stand-in
// *****
module fsl_stack_model (
   input wire logic hclk,
   input wire logic preop_req,
   output fsl_pkg::fsl_net_s net,
   output fsl_pkg::fsl_bp_s bp,
   output logic field_pwr_ok
);
   initial begin
      net = '0;
      bp = '0;
      field_pwr_ok = 1'b0;
   end
   // levels move only just after an edge
   task automatic put(input fsl_pkg::fsl_net_s n, input fsl_pkg::fsl_bp_s b, input logic fp);
      @(posedge hclk);
      net <= n;
      bp <= b;
      field_pwr_ok <= fp;
   endtask
   // the stack obeys the fall-back request at once
   always @(posedge hclk) begin
      if (preop_req) begin
         net.nmt <= fsl_pkg::NMT_PREOP;
      end
   end
endmodule
`default_nettype wire

// ### bench/test_fieldbus_adapter_status_leds.sv
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_adapter_status_leds;
   localparam int PH = 4;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, led_run_g, led_err_r, led_io_g, led_io_r, led_fp_g;
   logic pdo_en, preop_req, irq, field_pwr_ok, fp;
   logic [4:0] leds;
   fsl_pkg::fsl_net_s net, n;
   fsl_pkg::fsl_bp_s bp, b;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   assign leds = {led_fp_g, led_io_r, led_io_g, led_err_r, led_run_g};
   fsl_top #(.PHASE_CYC(PH)) u_fsl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .net(net),
      .bp(bp), .field_pwr_ok(field_pwr_ok), .led_run_g(led_run_g), .led_err_r(led_err_r),
      .led_io_g(led_io_g), .led_io_r(led_io_r), .led_fp_g(led_fp_g), .pdo_en(pdo_en),
      .preop_req(preop_req), .irq(irq));
   fsl_stack_model m_stack (.hclk(hclk), .preop_req(preop_req), .net(net), .bp(bp),
      .field_pwr_ok(field_pwr_ok));
   initial begin
      forever #50 hclk = ~hclk;
   end
   // ceiling well above the roughly 13.4k cycles the tests need
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         $display("wrong value at %0t: run hung", $time);
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic apply();
      m_stack.put(n, b, fp);
   endtask
   // lit phases per 120: whole periods of every pattern, so start phase is irrelevant
   task automatic observe(input int r, e, g, x, f, input string s);
      int ex[5] = '{r, e, g, x, f};
      logic [31:0] c[5];
      foreach (c[i]) c[i] = 32'h0;
      repeat (12) @(posedge hclk);
      repeat (120 * PH) begin
         @(posedge hclk);
         foreach (c[i]) c[i] += 32'(leds[i]);
      end
      foreach (c[i]) chk(c[i], 32'(ex[i] * PH), $sformatf("%s lamp %0d", s, i));
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic trip(input logic sync);
      n.sync_err = sync;
      n.guard_trip = !sync;
      apply();
      n.sync_err = 1'b0;
      n.guard_trip = 1'b0;
      apply();
      repeat (3) @(posedge hclk);
      n.nmt = net.nmt;
   endtask
   task automatic t_regs();
      logic [31:0] d;
      bus(1'b0, fsl_pkg::ADDR_CTRL, 32'h0, d);
      chk(d, {30'h0, fsl_pkg::CTRL_RST}, "ctrl reset");
      bus(1'b0, fsl_pkg::ADDR_INT_EN, 32'h0, d);
      chk(d, 32'h0, "enable reset");
      bus(1'b1, 8'h14, 32'hFFFFFFFF, d);
      bus(1'b0, 8'h14, 32'h0, d);
      chk(d, 32'h0, "unmapped");
      bus(1'b1, fsl_pkg::ADDR_INT_EN, 32'h1, d);
      n.bus_off = 1'b1;
      apply();
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h1, "irq raised");
      bus(1'b0, fsl_pkg::ADDR_INT_STAT, 32'h0, d);
      chk(d, 32'h1, "status bit");
      bus(1'b1, fsl_pkg::ADDR_INT_EN, 32'h0, d);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0, "irq masked");
      bus(1'b1, fsl_pkg::ADDR_INT_EN, 32'h1, d);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h1, "irq unmasked");
      bus(1'b1, fsl_pkg::ADDR_INT_CLR, 32'h1, d);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0, "irq cleared");
      bus(1'b0, fsl_pkg::ADDR_INT_STAT, 32'h0, d);
      chk(d, 32'h0, "status cleared");
      $display("register test done");
   endtask
   task automatic t_run();
      n = '0;
      n.unit_pwr = 1'b1;
      n.nmt = fsl_pkg::NMT_OPER;
      apply();
      observe(0, 0, 0, 0, 0, "off-line");
      n.online = 1'b1;
      apply();
      observe(120, 0, 0, 0, 0, "operational");
      n.nmt = fsl_pkg::NMT_STOPPED;
      apply();
      observe(20, 0, 0, 0, 0, "stopped");
      n.nmt = fsl_pkg::NMT_PREOP;
      apply();
      observe(60, 0, 0, 0, 0, "pre-operational");
      n.unit_pwr = 1'b0;
      apply();
      observe(0, 0, 0, 0, 0, "unpowered");
      $display("run lamp test done");
   endtask
   task automatic t_err();
      logic [31:0] d;
      n.unit_pwr = 1'b1;
      n.nmt = fsl_pkg::NMT_OPER;
      apply();
      observe(120, 0, 0, 0, 0, "quiet");
      chk(32'(pdo_en), 32'h1, "process data on");
      n.can_warn = 1'b1;
      apply();
      observe(120, 20, 0, 0, 0, "warning");
      trip(1'b0);
      chk(32'(net.nmt), 32'(fsl_pkg::NMT_PREOP), "guard fall-back");
      observe(60, 30, 0, 0, 0, "guarding");
      n.nmt = fsl_pkg::NMT_OPER;
      apply();
      trip(1'b1);
      chk(32'(net.nmt), 32'(fsl_pkg::NMT_PREOP), "sync fall-back");
      chk(32'(pdo_en), 32'h0, "process data off");
      // nmt pre-op, sync latch only, process data off
      bus(1'b0, fsl_pkg::ADDR_STATUS, 32'h0, d);
      chk(32'(d[14:8]), 32'h42, "status latches");
      trip(1'b0);
      observe(60, 36, 0, 0, 0, "sync");
      n.bus_off = 1'b1;
      apply();
      observe(60, 120, 0, 0, 0, "bus-off");
      n.bus_off = 1'b0;
      n.can_warn = 1'b0;
      n.nmt = fsl_pkg::NMT_OPER;
      apply();
      observe(120, 0, 0, 0, 0, "recovered");
      $display("error lamp test done");
   endtask
   task automatic t_io();
      logic [31:0] d;
      b = '0;
      b.mod_count = 6'h20;
      b.in_bytes = 8'h40;
      b.out_bytes = 8'h40;
      apply();
      observe(120, 0, 0, 0, 0, "no modules");
      b.present = 1'b1;
      apply();
      observe(120, 0, 0, 0, 0, "unpowered");
      b.powered = 1'b1;
      b.online = 1'b1;
      apply();
      observe(120, 0, 60, 0, 0, "initialising");
      // lamp test and disable placed where no port check expects a dark lamp
      bus(1'b1, fsl_pkg::ADDR_CTRL, 32'h3, d);
      observe(120, 120, 120, 120, 120, "lamp test");
      bus(1'b1, fsl_pkg::ADDR_CTRL, 32'h0, d);
      observe(0, 0, 0, 0, 0, "disabled");
      bus(1'b1, fsl_pkg::ADDR_CTRL, 32'h1, d);
      b.exch = 1'b1;
      b.init_done = 1'b1;
      apply();
      observe(120, 0, 120, 0, 0, "exchanging");
      for (int k = 0; k < 3; k++) begin
         b.mod_fault = (k == 0);
         b.cfg_changed = (k == 1);
         b.comm_fail = (k == 2);
         apply();
         observe(120, 0, 0, 120, 0, "exchange fault");
      end
      b.comm_fail = 1'b0;
      b.exch = 1'b0;
      b.init_done = 1'b0;
      for (int k = 0; k < 5; k++) begin
         b.bad_id = (k == 0);
         b.mod_count = (k == 1) ? 6'h21 : 6'h20;
         b.in_bytes = (k == 2) ? 8'h41 : 8'h40;
         b.out_bytes = (k == 3) ? 8'h41 : 8'h40;
         b.proto_fail = (k == 4);
         apply();
         observe(120, 0, 0, 60, 0, "init failure");
      end
      fp = 1'b1;
      apply();
      observe(120, 0, 0, 60, 120, "field power");
      fp = 1'b0;
      apply();
      observe(120, 0, 0, 60, 0, "field power lost");
      // every event kind has occurred since the clear in the register test
      bus(1'b0, fsl_pkg::ADDR_INT_STAT, 32'h0, d);
      chk(d, 32'h3F, "every event latched");
      $display("backplane and field lamp test done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      n = '0;
      b = '0;
      fp = 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_run();
      t_err();
      t_io();
      tally_and_finish();
   end
endmodule
`default_nettype wire
